// ==== rtl/phy_rx_status_tenbase_ctrl.v ====
`include "phy_rx_status_regs.vh"
`default_nettype none

// Summary of operation
// - bit 11 progress lsb, bit 4 negotiation done
// - latch signal loss, PLL error, false carrier
// - latch invalid, halt, premature end symbols
// - latch jabber, remote fault; link latches low
// - latch remote jabber and reversed polarity
// - float bit tri-states RMII receive outputs
// - gate bit zero allows vendor registers
// - test mux select, zero routes second mux
// - auto polarity inhibit stops polarity correction
// - jabber, SQE and squelch inhibit bits
// - link loss inhibit forces link pass
module phy_rx_status_tenbase_ctrl #(
	parameter [4:0] PHY_ADDR = 5'h01
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// management bus pins
	input  wire        mdc,
	input  wire        mdioIn,
	output reg         mdioOut,
	output reg         mdioOe,
	// straps caught after reset
	input  wire        strapCrossover,
	input  wire        strapRxFloat,
	input  wire        strapVendorGate,
	// status from the receive and negotiation logic
	input  wire [2:0]  anProgress,
	input  wire        anComplete,
	input  wire        txSignalLost,
	input  wire        pllLockErr,
	input  wire        falseCarrier,
	input  wire        invalidSymbol,
	input  wire        haltSymbol,
	input  wire        prematureEnd,
	input  wire        noSignal,
	input  wire        jabber,
	input  wire        remoteFault,
	input  wire        linkValid,
	input  wire        remoteJabber,
	input  wire        polarityReversed,
	// controls to the rest of the device
	output reg         crossoverAutoEnable,
	output reg         rxOutputFloat,
	output reg         rxOutputEnable,
	output reg         vendorRegGate,
	output reg         vendorAccessEn,
	output reg         testMuxSelect,
	output reg         polarityCorrectEn,
	output reg         jabberInhibit,
	output reg         sqeInhibit,
	output reg         squelchInhibit,
	output reg         linkForcePass
);

	// one-hot frame states
	localparam [4:0] ST_PRE  = 5'h01;
	localparam [4:0] ST_HDR  = 5'h02;
	localparam [4:0] ST_TA   = 5'h04;
	localparam [4:0] ST_RD   = 5'h08;
	localparam [4:0] ST_WR   = 5'h10;

	reg        mdcMeta;     // first stage, read by mdcSync only
	reg        mdcSync;     // synchronised mdc
	reg        mdcLast;     // previous synchronised mdc
	reg        mdioMeta;    // first stage, read by mdioSync only
	reg        mdioSync;    // synchronised data in
	reg        strapDone;   // straps captured
	reg [4:0]  state;       // frame state
	reg [5:0]  bitCnt;      // bits seen in current phase
	reg [11:0] hdr;         // op, phy address, register address
	reg [15:0] shiftReg;    // read data out or write data in
	reg        startBit;    // first start bit seen
	reg [2:0]  progMax;     // highest progress since last detail status read
	reg [9:0]  latchHigh;   // latched-high event flags
	reg        linkLatch;   // latched-low link flag

	wire        mdcRise = mdcSync & ~mdcLast;
	wire [1:0]  hdrOp   = hdr[11:10];
	wire [4:0]  hdrPhy  = hdr[9:5];
	wire [4:0]  hdrReg  = hdr[4:0];
	// live event vector, order matches latchHigh
	wire [9:0]  events  = {polarityReversed, remoteJabber, remoteFault, jabber,
	                       prematureEnd, haltSymbol, invalidSymbol, falseCarrier,
	                       pllLockErr, txSignalLost};
	wire [9:0]  flagNow = latchHigh | events;
	wire [2:0]  progNow = (anProgress > progMax) ? anProgress : progMax;

	// header decode used at several places
	function isReg;
		input [11:0] h;
		input [4:0]  r;
		begin
			isReg = (h[9:5] == PHY_ADDR) && (h[4:0] == r);
		end
	endfunction

	// detailed status word as read now
	reg [15:0] detailWord;
	always @*
	begin
		detailWord = 16'h0000;
		detailWord[`DS_PROGRESS_LSB]   = progNow[0];
		detailWord[`DS_AN_COMPLETE]    = anComplete;
		detailWord[`DS_TX_SIGNAL_LOST] = flagNow[0];
		detailWord[`DS_PLL_LOCK_ERR]   = flagNow[1];
		detailWord[`DS_FALSE_CARRIER]  = flagNow[2];
		detailWord[`DS_NO_SIGNAL]      = strapDone ? noSignal : `RST_NO_SIGNAL;
		detailWord[`DS_INVALID_SYMBOL] = flagNow[3];
		detailWord[`DS_HALT_SYMBOL]    = flagNow[4];
		detailWord[`DS_PREMATURE_END]  = flagNow[5];
		detailWord[`DS_JABBER]         = flagNow[6];
		detailWord[`DS_REMOTE_FAULT]   = flagNow[7];
		detailWord[`DS_LINK_STATUS]    = linkLatch & linkValid;
	end

	// tenbase operations word as read now
	reg [15:0] tenWord;
	always @*
	begin
		tenWord = 16'h0000;
		tenWord[`TB_REMOTE_JABBER] = flagNow[8];
		tenWord[`TB_POLARITY_REV]  = flagNow[9];
		tenWord[`TB_BUS_MODE_HI:`TB_BUS_MODE_LO] = `BUS_MODE_RMII;
		tenWord[`TB_CROSSOVER_EN]  = crossoverAutoEnable;
		tenWord[`TB_RX_FLOAT]      = rxOutputFloat;
		tenWord[`TB_VENDOR_GATE]   = vendorRegGate;
		tenWord[`TB_TEST_MUX_SEL]  = testMuxSelect;
		tenWord[`TB_JABBER_INH]    = jabberInhibit;
		tenWord[`TB_RESERVED_ONE]  = 1'h1;
		tenWord[`TB_AUTO_POL_INH]  = ~polarityCorrectEn;
		tenWord[`TB_SQE_INH]       = sqeInhibit;
		tenWord[`TB_LINK_LOSS_INH] = linkForcePass;
		tenWord[`TB_SQUELCH_INH]   = squelchInhibit;
	end

	// two-stage synchronisers for the bus pins
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			mdcMeta  <= 1'h0;
			mdcSync  <= 1'h0;
			mdcLast  <= 1'h0;
			mdioMeta <= 1'h1;
			mdioSync <= 1'h1;
		end
		else
		begin
			mdcMeta  <= mdc;
			mdcSync  <= mdcMeta;
			mdcLast  <= mdcSync;
			mdioMeta <= mdioIn;
			mdioSync <= mdioMeta;
		end
	end

	// read happens when the read header of a register completes
	wire hdrDone  = state[1] & mdcRise & (bitCnt == `MGMT_HDR_BITS - 6'h01);
	wire [11:0] fullHdr = {hdr[10:0], mdioSync};
	wire readNow  = hdrDone && (fullHdr[11:10] == `MGMT_OP_READ);
	wire rdDetail = readNow && isReg(fullHdr, `REG_DETAIL_STATUS);

	// latched status: events set, a read reloads from live state
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			latchHigh <= 10'h000;
			linkLatch <= 1'h0;
			progMax   <= 3'h0;
		end
		else if (rdDetail || (readNow && isReg(fullHdr, `REG_TENBASE_OPS)))
		begin
			// reload only the flags of the register read; set wins
			if (rdDetail)
			begin
				latchHigh[7:0] <= events[7:0];
				latchHigh[9:8] <= flagNow[9:8];
				linkLatch      <= 1'h1;
				progMax        <= anProgress;
			end
			else
			begin
				latchHigh[9:8] <= events[9:8];
				latchHigh[7:0] <= flagNow[7:0];
				linkLatch      <= linkLatch & linkValid;
				progMax        <= progNow;
			end
		end
		else
		begin
			latchHigh <= flagNow;
			linkLatch <= linkLatch & linkValid | ~strapDone;
			progMax   <= progNow;
		end
	end

	// management frame engine and control register
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state               <= ST_PRE;
			bitCnt              <= 6'h00;
			hdr                 <= 12'h000;
			shiftReg            <= 16'h0000;
			startBit            <= 1'h0;
			mdioOut             <= 1'h0;
			mdioOe              <= 1'h0;
			strapDone           <= 1'h0;
			crossoverAutoEnable <= 1'h0;
			rxOutputFloat       <= 1'h0;
			rxOutputEnable      <= 1'h0;
			vendorRegGate       <= 1'h0;
			vendorAccessEn      <= 1'h0;
			testMuxSelect       <= `RST_CTRL_BIT;
			polarityCorrectEn   <= 1'h0;
			jabberInhibit       <= `RST_CTRL_BIT;
			sqeInhibit          <= `RST_CTRL_BIT;
			squelchInhibit      <= `RST_CTRL_BIT;
			linkForcePass       <= `RST_CTRL_BIT;
		end
		else
		begin
			// straps and derived outputs settle on the first edge after release
			if (!strapDone)
			begin
				strapDone           <= 1'h1;
				crossoverAutoEnable <= strapCrossover;
				rxOutputFloat       <= strapRxFloat;
				rxOutputEnable      <= ~strapRxFloat;
				vendorRegGate       <= strapVendorGate;
				vendorAccessEn      <= ~strapVendorGate;
				polarityCorrectEn   <= 1'h1;
			end
			if (mdcRise)
			begin
				case (state)
					// count ones, then look for the start pattern
					ST_PRE:
					begin
						mdioOe <= 1'h0;
						if (mdioSync)
						begin
							if (startBit)
							begin
								state    <= ST_HDR;
								bitCnt   <= 6'h00;
								startBit <= 1'h0;
							end
							else if (bitCnt != `MGMT_PREAMBLE_BITS)
								bitCnt <= bitCnt + 6'h01;
						end
						else
						begin
							startBit <= (bitCnt == `MGMT_PREAMBLE_BITS);
							bitCnt   <= 6'h00;
						end
					end
					// collect op, phy and register address
					ST_HDR:
					begin
						hdr    <= fullHdr;
						bitCnt <= bitCnt + 6'h01;
						if (bitCnt == `MGMT_HDR_BITS - 6'h01)
						begin
							bitCnt <= 6'h00;
							if (fullHdr[9:5] != PHY_ADDR)
								state <= ST_PRE;
							else
								state <= ST_TA;
							if (isReg(fullHdr, `REG_DETAIL_STATUS))
								shiftReg <= detailWord;
							else if (isReg(fullHdr, `REG_TENBASE_OPS))
								shiftReg <= tenWord;
							else
								shiftReg <= 16'h0000;
						end
					end
					// turnaround: drive zero on its second bit for reads
					ST_TA:
					begin
						if (hdrOp == `MGMT_OP_READ)
						begin
							mdioOe  <= 1'h1;
							mdioOut <= 1'h0;
							state   <= ST_RD;
						end
						else if (hdrOp == `MGMT_OP_WRITE)
						begin
							bitCnt <= bitCnt + 6'h01;
							if (bitCnt == 6'h01)
							begin
								bitCnt <= 6'h00;
								state  <= ST_WR;
							end
						end
						else
							state <= ST_PRE;
					end
					// shift read data out msb first
					ST_RD:
					begin
						bitCnt <= bitCnt + 6'h01;
						if (bitCnt == `MGMT_DATA_BITS)
						begin
							mdioOe <= 1'h0;
							bitCnt <= 6'h00;
							state  <= ST_PRE;
						end
						else
						begin
							mdioOut  <= shiftReg[15];
							shiftReg <= {shiftReg[14:0], 1'h0};
						end
					end
					// shift write data in, commit on the last bit
					ST_WR:
					begin
						shiftReg <= {shiftReg[14:0], mdioSync};
						bitCnt   <= bitCnt + 6'h01;
						if (bitCnt == `MGMT_DATA_BITS - 6'h01)
						begin
							bitCnt <= 6'h00;
							state  <= ST_PRE;
							if (hdrReg == `REG_TENBASE_OPS)
							begin
								crossoverAutoEnable <= shiftReg[`TB_CROSSOVER_EN - 1];
								rxOutputFloat       <= shiftReg[`TB_RX_FLOAT - 1];
								rxOutputEnable      <= ~shiftReg[`TB_RX_FLOAT - 1];
								vendorRegGate       <= shiftReg[`TB_VENDOR_GATE - 1];
								vendorAccessEn      <= ~shiftReg[`TB_VENDOR_GATE - 1];
								testMuxSelect       <= shiftReg[`TB_TEST_MUX_SEL - 1];
								jabberInhibit       <= shiftReg[`TB_JABBER_INH - 1];
								polarityCorrectEn   <= ~shiftReg[`TB_AUTO_POL_INH - 1];
								sqeInhibit          <= shiftReg[`TB_SQE_INH - 1];
								linkForcePass       <= shiftReg[`TB_LINK_LOSS_INH - 1];
								squelchInhibit      <= mdioSync;
							end
						end
					end
					default:
					begin
						state  <= ST_PRE;
						mdioOe <= 1'h0;
					end
				endcase
			end
		end
	end

endmodule // phy_rx_status_tenbase_ctrl

`default_nettype wire

// ==== rtl/phy_rx_status_regs.vh ====
`ifndef PHY_RX_STATUS_REGS_VH
`define PHY_RX_STATUS_REGS_VH

// register addresses on the management bus
`define REG_DETAIL_STATUS    5'h11
`define REG_TENBASE_OPS      5'h12

// detailed status bit positions
`define DS_PROGRESS_LSB      11
`define DS_TX_SIGNAL_LOST    10
`define DS_PLL_LOCK_ERR      9
`define DS_FALSE_CARRIER     8
`define DS_INVALID_SYMBOL    7
`define DS_HALT_SYMBOL       6
`define DS_PREMATURE_END     5
`define DS_AN_COMPLETE       4
`define DS_NO_SIGNAL         3
`define DS_JABBER            2
`define DS_REMOTE_FAULT      1
`define DS_LINK_STATUS       0

// tenbase operations bit positions
`define TB_REMOTE_JABBER     15
`define TB_POLARITY_REV      14
`define TB_BUS_MODE_HI       13
`define TB_BUS_MODE_LO       12
`define TB_CROSSOVER_EN      11
`define TB_RX_FLOAT          10
`define TB_VENDOR_GATE       9
`define TB_TEST_MUX_SEL      8
`define TB_JABBER_INH        5
`define TB_RESERVED_ONE      4
`define TB_AUTO_POL_INH      3
`define TB_SQE_INH           2
`define TB_LINK_LOSS_INH     1
`define TB_SQUELCH_INH       0

// fixed read values and reset values
`define BUS_MODE_RMII        2'h2
`define RST_NO_SIGNAL        1'h1
`define RST_CTRL_BIT         1'h0

// management frame timing in mdc bit periods and op codes
`define MGMT_PREAMBLE_BITS   6'h20
`define MGMT_HDR_BITS        6'h0C
`define MGMT_DATA_BITS       6'h10
`define MGMT_OP_READ         2'h2
`define MGMT_OP_WRITE        2'h1

`endif

// ==== tb/phy_ctrl_monitor.sv ====
`default_nettype none
module phy_ctrl_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// watched pins
	input wire logic mdioOe,
	input wire logic strapRxFloat,
	input wire logic strapVendorGate,
	input wire logic rxOutputFloat,
	input wire logic rxOutputEnable,
	input wire logic vendorRegGate,
	input wire logic vendorAccessEn,
	input wire logic testMuxSelect,
	input wire logic polarityCorrectEn,
	input wire logic jabberInhibit,
	input wire logic sqeInhibit,
	input wire logic squelchInhibit,
	input wire logic linkForcePass
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// receive enable always opposes the float bit once loaded
	a_float_inverse: assert property (!$past(rst) |-> rxOutputEnable != rxOutputFloat)
		else $error("rx enable not inverse of float");
	// vendor access always opposes the gate bit once loaded
	a_gate_inverse: assert property (!$past(rst) |-> vendorAccessEn != vendorRegGate)
		else $error("vendor access not inverse of gate");
	// straps land in the control bits on the first edge
	a_strap_load: assert property ($fell(rst) |=> rxOutputFloat == $past(strapRxFloat)
		&& vendorRegGate == $past(strapVendorGate))
		else $error("straps not loaded");
	// polarity correction on after reset
	a_polarity_reset: assert property ($fell(rst) |=> polarityCorrectEn)
		else $error("polarity correction off after reset");
	// check jabber, SQE and squelch inhibits clear after reset
	a_inhibit_reset: assert property ($fell(rst) |=> !(jabberInhibit | sqeInhibit | squelchInhibit))
		else $error("inhibit set after reset");
	// test mux routes second onto first after reset
	a_mux_reset: assert property ($fell(rst) |=> !testMuxSelect)
		else $error("test mux select set after reset");
	// link loss detection normal after reset
	a_force_reset: assert property ($fell(rst) |=> !linkForcePass)
		else $error("link forced after reset");
	// a read frame never disturbs the jabber, SQE, squelch, link force and test mux controls
	a_read_holds: assert property (mdioOe |-> $stable({jabberInhibit, sqeInhibit, squelchInhibit,
		linkForcePass, testMuxSelect}))
		else $error("control changed during read");
endmodule // phy_ctrl_monitor
`default_nettype wire

// ==== tb/mgmt_station.sv ====
`default_nettype none
module mgmt_station (
	// management pins
	output logic      mdc,
	output logic      staVal,
	output logic      staEn,
	input  wire logic mdioWire
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock idles low between frames
	initial
	begin
		mdc = 1'b0;
		staEn = 1'b0;
		staVal = 1'b1;
	end
	// one frame: preamble, start, op, address, turnaround, data
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 0; i < 64; i++)
		begin
			mdc = 1'b0;
			staEn = (i < 46) || (op == 2'h1);
			staVal = bits[63 - i];
			#62.5;
			mdc = 1'b1;
			#62.5;
			// read bits settle well before the end of the high phase
			if (i >= 47 && i <= 62)
				rd[62 - i] = mdioWire;
		end
		mdc = 1'b0;
		staEn = 1'b0;
		#62.5;
	endtask
endmodule // mgmt_station
`default_nettype wire

// ==== tb/tb.sv ====
`include "phy_rx_status_regs.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// stimulus
	logic        ref_clk, rst, mdc, staVal, staEn;
	logic [2:0]  anProgress;
	logic        anComplete, noSignal, linkValid, remoteJabber, polarityReversed;
	logic [7:0]  ev;
	wire         mdioOut, mdioOe;
	wire  [10:0] ctrl;
	// pulled-up mdio line
	wire         mdioWire = mdioOe ? mdioOut : (staEn ? staVal : 1'b1);
	int          errors, num_checks, cyc;
	int          pos [8] = '{10, 9, 8, 7, 6, 5, 2, 1};
	mgmt_station sta (.mdc, .staVal, .staEn, .mdioWire);
	phy_rx_status_tenbase_ctrl dut (.ref_clk, .rst, .mdc, .mdioIn(mdioWire), .mdioOut,
		.mdioOe, .strapCrossover(1'b1), .strapRxFloat(1'b0), .strapVendorGate(1'b1),
		.anProgress, .anComplete, .txSignalLost(ev[7]), .pllLockErr(ev[6]),
		.falseCarrier(ev[5]), .invalidSymbol(ev[4]), .haltSymbol(ev[3]),
		.prematureEnd(ev[2]), .noSignal, .jabber(ev[1]), .remoteFault(ev[0]), .linkValid,
		.remoteJabber, .polarityReversed, .crossoverAutoEnable(ctrl[10]),
		.rxOutputFloat(ctrl[9]), .rxOutputEnable(ctrl[8]), .vendorRegGate(ctrl[7]),
		.vendorAccessEn(ctrl[6]), .testMuxSelect(ctrl[5]), .polarityCorrectEn(ctrl[4]),
		.jabberInhibit(ctrl[3]), .sqeInhibit(ctrl[2]), .squelchInhibit(ctrl[1]),
		.linkForcePass(ctrl[0]));
	// control outputs expected from an operations word
	function automatic logic [15:0] ctrl_of(input logic [15:0] w);
		return {5'h00, w[11:10], ~w[10], w[9], ~w[9], w[8], ~w[3], w[5], w[2], w[0], w[1]};
	endfunction
	task automatic chk(input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] v;
		sta.xfer(`MGMT_OP_READ, 5'h01, ra, 16'h0000, v);
		chk(v, exp);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] w);
		logic [15:0] v;
		sta.xfer(`MGMT_OP_WRITE, 5'h01, ra, w, v);
		repeat (2) @(negedge ref_clk);
	endtask
	// reset values and strap loads
	task automatic t_reset;
		chk({5'h00, ctrl}, ctrl_of(16'h0A00));
		rd(`REG_DETAIL_STATUS, 16'h0009);
		rd(`REG_TENBASE_OPS, 16'h2A10);
	endtask
	// each event pulse holds until read, then clears
	task automatic t_flags;
		for (int k = 0; k < 8; k++)
		begin
			@(negedge ref_clk) ev = 8'h80 >> k;
			@(negedge ref_clk) ev = 8'h00;
			rd(`REG_DETAIL_STATUS, 16'h0009 | (16'h0001 << pos[k]));
			rd(`REG_DETAIL_STATUS, 16'h0009);
		end
		@(negedge ref_clk) linkValid = 1'b0;
		@(negedge ref_clk) linkValid = 1'b1;
		rd(`REG_DETAIL_STATUS, 16'h0008);
		rd(`REG_DETAIL_STATUS, 16'h0009);
		@(negedge ref_clk) {remoteJabber, polarityReversed} = 2'h3;
		@(negedge ref_clk) {remoteJabber, polarityReversed} = 2'h0;
		rd(`REG_TENBASE_OPS, 16'hEA10);
		rd(`REG_TENBASE_OPS, 16'h2A10);
	endtask
	// live bits and highest progress code
	task automatic t_live;
		@(negedge ref_clk) {anComplete, noSignal, anProgress} = 5'h15;
		@(negedge ref_clk) anProgress = 3'h2;
		rd(`REG_DETAIL_STATUS, 16'h0811);
		rd(`REG_DETAIL_STATUS, 16'h0011);
		@(negedge ref_clk) {anComplete, noSignal, anProgress} = 5'h08;
		rd(`REG_DETAIL_STATUS, 16'h0009);
	endtask
	// control writes reach outputs; read-only bits ignore writes
	task automatic t_write;
		logic [15:0] w [3] = '{16'hFFFF, 16'h0A25, 16'h0000};
		for (int k = 0; k < 3; k++)
		begin
			wr(`REG_TENBASE_OPS, w[k]);
			chk({5'h00, ctrl}, ctrl_of(w[k]));
			rd(`REG_TENBASE_OPS, (w[k] & 16'h0F2F) | 16'h2010);
		end
	endtask
	// refused accesses
	task automatic t_refused;
		logic [15:0] v;
		wr(`REG_DETAIL_STATUS, 16'hFFFF);
		rd(`REG_DETAIL_STATUS, 16'h0009);
		rd(5'h13, 16'h0000);
		sta.xfer(`MGMT_OP_READ, 5'h02, `REG_TENBASE_OPS, 16'h0000, v);
		chk(v, 16'hFFFF);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			wrap_up;
		end
	end
	// main sequence
	initial
	begin
		{rst, noSignal, linkValid} = 3'h7;
		{ev, anProgress, anComplete, remoteJabber, polarityReversed} = 14'h0000;
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		t_reset;
		t_flags;
		t_live;
		t_write;
		t_refused;
		wrap_up;
	end
endmodule // tb
bind phy_rx_status_tenbase_ctrl phy_ctrl_monitor mon (.ref_clk, .rst, .mdioOe, .strapRxFloat,
	.strapVendorGate, .rxOutputFloat, .rxOutputEnable, .vendorRegGate, .vendorAccessEn,
	.testMuxSelect, .polarityCorrectEn, .jabberInhibit, .sqeInhibit, .squelchInhibit,
	.linkForcePass);
`default_nettype wire
